//--- verilog/auto_restart.sv
// automatic restart supervisor after drive fault trips
`timescale 1ns/1ps
`default_nettype none
`include "restart_map.svh"
module auto_restart
  import restart_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // settings
  input  wire logic [3:0]  restart_budget_setting_i,
  input  wire logic [9:0]  restart_delay_setting_i,
  input  wire logic [3:0]  speed_search_select_i,
  // drive status
  input  wire logic        trip_i,
  input  wire logic [2:0]  trip_cause_i,
  input  wire logic        run_cmd_i,
  input  wire logic        manual_reset_i,
  // restart request
  output logic             restart_o,
  output logic             speed_search_o,
  output logic [3:0]       retries_left_o,
  output logic             locked_o
);
  // --------------------------------------------------------------------------
  // timebase
  // --------------------------------------------------------------------------
  logic tick;
  tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_i  (clk_i),
    .rst_b_i(rst_b_i),
    .tick_o (tick)
  );

  // --------------------------------------------------------------------------
  // settings, clamped to their legal ranges
  // --------------------------------------------------------------------------
  wire [3:0] budget = (restart_budget_setting_i > `BUDGET_MAX) ? `BUDGET_MAX
                      : restart_budget_setting_i;
  wire [9:0] delay  = (restart_delay_setting_i > `DELAY_MAX) ? `DELAY_MAX
                      : restart_delay_setting_i;

  function automatic logic excluded(input logic [2:0] cause);
    excluded = (cause == TRIP_UNDERVOLT) || (cause == TRIP_ESTOP) ||
               (cause == TRIP_OVERHEAT)  || (cause == TRIP_HW_DIAG);
  endfunction : excluded

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  restart_state_t state_reg, state_next;
  logic [3:0]     left_reg, left_next;
  logic [9:0]     wait_reg, wait_next;
  logic [8:0]     clean_reg, clean_next;
  logic           clean_arm_reg, clean_arm_next;
  logic [9:0]     delay_reg;

  wire trip_ok     = trip_i && !excluded(trip_cause_i) && (left_reg != 4'h0);
  wire delay_done  = (wait_reg >= delay_reg);
  wire fire        = (state_reg == ST_WAIT) && delay_done && run_cmd_i;
  wire clean_done  = clean_arm_reg && tick && (clean_reg == 9'(`CLEAN_TICKS - 1));

  always_comb begin
    state_next     = state_reg;
    left_next      = left_reg;
    wait_next      = wait_reg;
    clean_next     = clean_reg;
    clean_arm_next = clean_arm_reg;
    if (clean_arm_reg && tick) begin
      clean_next = clean_reg + 9'h001;
    end
    if (clean_done) begin
      left_next      = budget;
      clean_arm_next = 1'b0;
    end
    unique case (state_reg)
      ST_IDLE, ST_RUN: begin
        state_next = run_cmd_i ? ST_RUN : ST_IDLE;
        if (trip_i) begin
          clean_arm_next = 1'b0;
          state_next     = trip_ok ? ST_TRIPPED : ST_LOCKED;
        end
      end
      ST_TRIPPED: begin
        wait_next = 10'h000;
        if (run_cmd_i) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tick && !delay_done) begin
          wait_next = wait_reg + 10'h001;
        end
        if (fire) begin
          left_next      = left_reg - 4'h1;
          clean_next     = 9'h000;
          clean_arm_next = 1'b1;
          state_next     = ST_RUN;
        end
      end
      ST_LOCKED: state_next = ST_LOCKED;
      // an illegal code stops the drive rather than risk an unplanned restart
      default:   state_next = ST_LOCKED;
    endcase
    if (manual_reset_i) begin
      left_next      = budget;
      clean_arm_next = 1'b0;
      state_next     = ST_IDLE;
    end
  end

  // --------------------------------------------------------------------------
  // registers; delay is frozen while waiting so an edit cannot cut a wait short
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg      <= ST_IDLE;
      left_reg       <= `BUDGET_RESET;
      wait_reg       <= 10'h000;
      clean_reg      <= 9'h000;
      clean_arm_reg  <= 1'b0;
      delay_reg      <= `DELAY_RESET;
      restart_o      <= 1'b0;
      speed_search_o <= 1'b0;
      retries_left_o <= `BUDGET_RESET;
      locked_o       <= 1'b0;
    end else begin
      state_reg      <= state_next;
      left_reg       <= left_next;
      wait_reg       <= wait_next;
      clean_reg      <= clean_next;
      clean_arm_reg  <= clean_arm_next;
      delay_reg      <= (state_reg == ST_WAIT) ? delay_reg : delay;
      restart_o      <= fire && !manual_reset_i;
      speed_search_o <= fire && !manual_reset_i
                        && speed_search_select_i[`SEL_FAULT];
      retries_left_o <= left_next;
      locked_o       <= (state_next == ST_LOCKED);
    end
  end
endmodule : auto_restart
`default_nettype wire

//--- verilog/restart_map.svh
// constants for the automatic restart supervisor
`ifndef RESTART_MAP_SVH
`define RESTART_MAP_SVH

// ----------------------------------------------------------------------------
// settings
// ----------------------------------------------------------------------------
`define BUDGET_MAX        4'hA
`define BUDGET_RESET      4'h0
`define DELAY_MAX         10'h258
`define DELAY_RESET       10'h00A
`define SEL_RESET         4'h0

// ----------------------------------------------------------------------------
// timing: 10 MHz clock, 100 ns period
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     100
`define TICK_NS           100000000
`define TICK_CYCLES       (`TICK_NS / `CLK_PERIOD_NS)
`define CLEAN_TICKS       300

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define SEL_GENERAL       0
`define SEL_FAULT         1
`define SEL_POWER_LOSS    2
`define SEL_POWER_ON      3

`endif

//--- verilog/restart_pkg.sv
// types for the automatic restart supervisor
`default_nettype none
package restart_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RUN     = 3'b001,
    ST_TRIPPED = 3'b011,
    ST_WAIT    = 3'b010,
    ST_LOCKED  = 3'b110
  } restart_state_t;

  typedef enum logic [2:0] {
    TRIP_NONE      = 3'h0,
    TRIP_UNDERVOLT = 3'h1,
    TRIP_ESTOP     = 3'h2,
    TRIP_OVERHEAT  = 3'h3,
    TRIP_HW_DIAG   = 3'h4,
    TRIP_OTHER     = 3'h5
  } trip_cause_t;
endpackage : restart_pkg
`default_nettype wire

//--- verilog/tick_timer.sv
// timebase divider: one-cycle tick every 0.1 s
`timescale 1ns/1ps
`default_nettype none
`include "restart_map.svh"
module tick_timer #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // timebase
  output logic      tick_o
);
  logic [23:0] count_reg;
  wire         wrap = (count_reg == 24'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      count_reg <= 24'h000000;
      tick_o    <= 1'b0;
    end else begin
      count_reg <= wrap ? 24'h000000 : count_reg + 24'h000001;
      tick_o    <= wrap;
    end
  end
endmodule : tick_timer
`default_nettype wire

//--- tb/auto_restart_properties.sv
// concurrent checks on the automatic restart supervisor ports
`timescale 1ns/1ps
`default_nettype none
module auto_restart_properties (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  // settings
  input wire logic [3:0] restart_budget_setting_i,
  input wire logic [9:0] restart_delay_setting_i,
  input wire logic [3:0] speed_search_select_i,
  // drive status
  input wire logic       trip_i,
  input wire logic [2:0] trip_cause_i,
  input wire logic       run_cmd_i,
  input wire logic       manual_reset_i,
  // restart request
  input wire logic       restart_o,
  input wire logic       speed_search_o,
  input wire logic [3:0] retries_left_o,
  input wire logic       locked_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic excl = (trip_cause_i >= 3'h1) && (trip_cause_i <= 3'h4);
  sequence pulse_s;
    restart_o ##1 !restart_o;
  endsequence
  reset_clear_a: assert property (
    $rose(rst_b_i) |-> {locked_o, restart_o, retries_left_o} == 6'h00)
    else $error("outputs not clear");
  pulse_one_a: assert property (restart_o |-> pulse_s) else $error("long pulse");
  run_needed_a: assert property (restart_o |-> $past(run_cmd_i)) else $error("no run");
  count_down_a: assert property (
    restart_o |-> $past(retries_left_o) != 4'h0 &&
      retries_left_o == $past(retries_left_o) - 4'h1)
    else $error("bad count");
  manual_reload_a: assert property (
    manual_reset_i |=> !locked_o && retries_left_o ==
      ($past(restart_budget_setting_i) > 4'hA ? 4'hA : $past(restart_budget_setting_i)))
    else $error("no reload");
  search_pair_a: assert property (
    speed_search_o |-> restart_o && $past(speed_search_select_i[1]))
    else $error("bad search");
  locked_hold_a: assert property (
    locked_o && !manual_reset_i |=> locked_o && !restart_o)
    else $error("lock lost");
  excluded_lock_a: assert property (
    trip_i && excl && !locked_o && !manual_reset_i |-> ##[1:4] locked_o)
    else $error("no lock");
endmodule : auto_restart_properties
bind auto_restart auto_restart_properties chk (
  .clk_i                   (clk_i),
  .rst_b_i                 (rst_b_i),
  .restart_budget_setting_i(restart_budget_setting_i),
  .restart_delay_setting_i (restart_delay_setting_i),
  .speed_search_select_i   (speed_search_select_i),
  .trip_i                  (trip_i),
  .trip_cause_i            (trip_cause_i),
  .run_cmd_i               (run_cmd_i),
  .manual_reset_i          (manual_reset_i),
  .restart_o               (restart_o),
  .speed_search_o          (speed_search_o),
  .retries_left_o          (retries_left_o),
  .locked_o                (locked_o)
);
`default_nettype wire

//--- tb/drive_fault_model.sv
// model of the drive fault protection: one-cycle trip pulses with a cause
`timescale 1ns/1ps
`default_nettype none
module drive_fault_model (
  // clock
  input  wire logic       clk_i,
  // trip request from the bench
  input  wire logic       go_i,
  input  wire logic [2:0] cause_i,
  // trip towards the supervisor
  output var logic        trip_o = 1'b0,
  output var logic [2:0]  cause_o = 3'h0
);
  // cause only means something with the pulse, so it is scrambled otherwise
  always_ff @(posedge clk_i) begin
    trip_o  <= go_i;
    cause_o <= go_i ? cause_i : ~cause_o;
  end
endmodule : drive_fault_model
`default_nettype wire

//--- tb/auto_restart_tb.sv
// self-checking bench for the automatic restart supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
module auto_restart_tb;
  logic clk_i = 0, rst_b_i = 0, run = 1, mrst = 0, go = 0, trip, rs, ss, lk;
  logic [3:0] bud = 4'h0, sel = 4'h0, left;
  logic [9:0] dly = 10'h000;
  logic [2:0] cs = 3'h5, cause;
  int err_count = 0, n_compared = 0, seed = 5, n, d;
  always #50 clk_i = ~clk_i;
  drive_fault_model FM (.clk_i(clk_i), .go_i(go), .cause_i(cs), .trip_o(trip), .cause_o(cause));
  auto_restart #(.TICK_CYCLES(10)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .restart_budget_setting_i(bud), .restart_delay_setting_i(dly), .speed_search_select_i(sel),
    .trip_i(trip), .trip_cause_i(cause), .run_cmd_i(run), .manual_reset_i(mrst),
    .restart_o(rs), .speed_search_o(ss), .retries_left_o(left), .locked_o(lk));
  function logic [3:0] clamp(input logic [3:0] b);
    return (b > 4'hA) ? 4'hA : b;
  endfunction : clamp

  task end_of_test;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // waits at most 400 cycles for a restart pulse; n tells how long it took
  task await;
    n = 0;
    while (rs !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
  endtask : await

  task fault(input logic [2:0] c);
    cs <= c;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    await;
  endtask : fault

  task clr;
    @(posedge clk_i);
    mrst <= 1'b1;
    @(posedge clk_i);
    mrst <= 1'b0;
  endtask : clr

  // the whole sequence needs under 10,000 cycles; a hang is cut at 50,000
  initial begin
    #5000000;
    err_count++;
    end_of_test;
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    `CHK({lk, rs, left}, 6'h00)
    @(posedge clk_i);
    fault(3'h5);
    `CHK({rs, lk}, 2'b01)
    @(posedge clk_i);
    bud <= 4'hF;
    clr;
    @(negedge clk_i);
    `CHK({lk, left}, {1'b0, clamp(bud)})
    for (int i = 9; i >= 0; i--) begin
      @(posedge clk_i);
      d = {$random(seed)} % 4;
      sel <= 4'($random(seed));
      dly <= 10'(d);
      run <= (i != 5);
      @(posedge clk_i);
      fault(3'h5);
      if (i == 5) begin
        `CHK(rs, 1'b0)
        @(posedge clk_i);
        run <= 1'b1;
        await;
      end
      `CHK(i == 5 || (n <= d * 10 + 12 && n + 8 >= d * 10), 1'b1)
      `CHK({rs, ss, left}, {1'b1, sel[1], 4'(i)})
    end
    @(posedge clk_i);
    fault(3'h5);
    `CHK({rs, lk}, 2'b01)
    for (int c = 1; c < 5; c++) begin
      clr;
      fault(3'(c));
      `CHK({rs, lk, left}, 6'h1A)
    end
    clr;
    fault(3'h5);
    `CHK(left, 4'h9)
    // 30 s is 300 ticks of 10 cycles: no reload before, a reload soon after
    repeat (2900) @(negedge clk_i);
    `CHK(left, 4'h9)
    repeat (200) @(negedge clk_i);
    `CHK(left, 4'hA)
    end_of_test;
  end
endmodule : auto_restart_tb
`default_nettype wire
